// [logic/ebhco_pkg.sv]
// shared constants for the bus hold and clock-out block
package ebhco_pkg;
    localparam int unsigned CLK_DIV_DEFAULT = 2;  // mclk cycles per machine cycle
    localparam logic SEL_HOST_PORT = 1'h0;       // interface select: host port mode
    localparam logic SEL_EXT_MEM = 1'h1;         // interface select: external memory mode
    localparam logic CLK_OUT_RESET = 1'h1;       // clock out level after reset
    typedef enum logic [1:0] {
        EBH_RUN = 2'h0,
        EBH_DRAIN = 2'h1,
        EBH_HOLD = 2'h2
    } ebhco_state_type;
endpackage : ebhco_pkg

// [logic/ebhco_top.sv]
// bus hold handshake, select pin mux and machine-cycle clock output
module ebhco_top #(
    parameter int unsigned CLK_DIV = ebhco_pkg::CLK_DIV_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ext_interface_select,
    input wire logic off_n,
    input wire logic emulation_pin_1,
    input wire logic hold_req_n,
    input wire logic bus_cycle_busy,
    input wire logic clock_pin_disable,
    input wire logic program_addr_bit18,
    input wire logic subsystem_select_in,
    output logic subsystem_select_r,
    output logic subsystem_select_out_r,
    output logic subsystem_select_oe_r,
    output logic bus_release_r,
    output logic hold_acknowledge_n_r,
    output logic hold_acknowledge_oe_r,
    output logic machine_cycle_clock_out_r,
    output logic machine_cycle_clock_out_oe_r,
    output logic machine_cycle_en_r
);
    // mclk stands for the pll output clock
    localparam int unsigned CNT_W = $clog2(CLK_DIV + 1);

    // divider end points at counter width
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(CLK_DIV - 1);
    localparam logic [CNT_W-1:0] DIV_HALF = CNT_W'(CLK_DIV / 2 - 1);

    // hold handshake state
    ebhco_pkg::ebhco_state_type state_r;
    ebhco_pkg::ebhco_state_type state_nxt;

    // machine-cycle divider count
    logic [CNT_W-1:0] div_cnt_r;
    logic [CNT_W-1:0] div_cnt_nxt;

    // divider decodes
    logic div_wrap;
    logic div_half;

    // pin mode and float decodes
    logic host_mode;
    logic ext_mode;
    logic float_req;

    // hold decodes
    logic hold_asked;
    logic hold_next;

    // clock-out drive decode
    logic clk_out_drive;

    // divider end-point compare and count step
    assign div_wrap = (div_cnt_r == DIV_LAST);
    assign div_half = (div_cnt_r == DIV_HALF);
    assign div_cnt_nxt = div_wrap ? '0 : div_cnt_r + 1'b1;

    // select pin mode, float control
    assign host_mode = (ext_interface_select == ebhco_pkg::SEL_HOST_PORT);
    assign ext_mode = (ext_interface_select == ebhco_pkg::SEL_EXT_MEM);
    assign float_req = ~off_n;

    // hold request and hold-next decode
    assign hold_asked = ~hold_req_n;
    assign hold_next = (state_nxt == ebhco_pkg::EBH_HOLD);

    // clock out driven unless disabled or floated
    assign clk_out_drive = emulation_pin_1 & ~clock_pin_disable;

    // machine-cycle divider counter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

    // one-cycle pulse per machine cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            machine_cycle_en_r <= 1'h0;
        end else begin
            machine_cycle_en_r <= div_wrap;
        end
    end

    // clock out level: falls at cycle start, rises mid-cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            machine_cycle_clock_out_r <= ebhco_pkg::CLK_OUT_RESET;
        end else if (div_wrap) begin
            machine_cycle_clock_out_r <= 1'h0;
        end else if (div_half) begin
            machine_cycle_clock_out_r <= 1'h1;
        end
    end

    // clock out enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            machine_cycle_clock_out_oe_r <= 1'h0;
        end else begin
            machine_cycle_clock_out_oe_r <= clk_out_drive;
        end
    end

    // subsystem choice, sampled only in host mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            subsystem_select_r <= 1'h0;
        end else if (host_mode) begin
            subsystem_select_r <= subsystem_select_in;
        end else begin
            subsystem_select_r <= subsystem_select_r; // held in external-memory mode
        end
    end

    // select pin data: address bit 18
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            subsystem_select_out_r <= 1'h0;
        end else begin
            subsystem_select_out_r <= program_addr_bit18;
        end
    end

    // select pin enable, off in host mode or float
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            subsystem_select_oe_r <= 1'h0;
        end else begin
            subsystem_select_oe_r <= ext_mode & ~float_req;
        end
    end

    // hold handshake next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ebhco_pkg::EBH_RUN: begin
                if (hold_asked) begin
                    state_nxt = ebhco_pkg::EBH_DRAIN;
                end
            end
            ebhco_pkg::EBH_DRAIN: begin
                if (!hold_asked) begin
                    state_nxt = ebhco_pkg::EBH_RUN;
                end else if (!bus_cycle_busy) begin
                    state_nxt = ebhco_pkg::EBH_HOLD;
                end
            end
            ebhco_pkg::EBH_HOLD: begin
                if (!hold_asked) begin
                    state_nxt = ebhco_pkg::EBH_RUN;
                end
            end
            default: begin
                state_nxt = ebhco_pkg::EBH_RUN;
            end
        endcase
    end

    // hold state register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ebhco_pkg::EBH_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bus lines released while in hold
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bus_release_r <= 1'h0;
        end else begin
            bus_release_r <= hold_next;
        end
    end

    // hold acknowledge, active low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_acknowledge_n_r <= 1'h1;
        end else begin
            hold_acknowledge_n_r <= ~hold_next;
        end
    end

    // hold acknowledge pin enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_acknowledge_oe_r <= 1'h0;
        end else begin
            hold_acknowledge_oe_r <= ~float_req;
        end
    end
endmodule : ebhco_top

// [test/ebhco_assertions.sv]
// checker for hold handshake, pin floats and clock-out enable
module ebhco_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic off_n,
    input wire logic emulation_pin_1,
    input wire logic ext_interface_select,
    input wire logic clock_pin_disable,
    input wire logic bus_cycle_busy,
    input wire logic hold_req_n,
    input wire logic hold_acknowledge_n_r,
    input wire logic hold_acknowledge_oe_r,
    input wire logic bus_release_r,
    input wire logic subsystem_select_oe_r,
    input wire logic machine_cycle_clock_out_oe_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ack_needs_release_a: assert property (!hold_acknowledge_n_r |-> bus_release_r)
        else $error("ack without release");
    ack_float_a: assert property (!off_n |=> !hold_acknowledge_oe_r) else $error("ack");
    sel_float_a: assert property (!off_n |=> !subsystem_select_oe_r) else $error("sel");
    sel_input_a: assert property (!ext_interface_select |=> !subsystem_select_oe_r)
        else $error("sel driven");
    sel_drive_a: assert property (off_n && ext_interface_select |=> subsystem_select_oe_r)
        else $error("sel idle");
    clk_float_a: assert property (!emulation_pin_1 |=> !machine_cycle_clock_out_oe_r)
        else $error("clk float");
    clk_off_a: assert property (clock_pin_disable |=> !machine_cycle_clock_out_oe_r)
        else $error("clk off");
    ack_wait_a: assert property (bus_cycle_busy && hold_acknowledge_n_r |=> hold_acknowledge_n_r)
        else $error("early ack");
    ack_drop_a: assert property (hold_req_n && !hold_acknowledge_n_r |=> hold_acknowledge_n_r)
        else $error("ack stuck");
endmodule : ebhco_chk
bind ebhco_top ebhco_chk i_chk (.*);

// [test/ebhco_partner.sv]
// external bus master model: asks for hold, runs bus cycles
module ebhco_partner (
    input wire logic want,
    input wire logic busy,
    output logic hold_req_n,
    output logic bus_cycle_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // request held low for as long as the master wants the bus
    assign hold_req_n = !want;
    assign bus_cycle_busy = busy;
endmodule : ebhco_partner

// [test/ebhco_top_tb.sv]
// testbench for bus hold, select pin and clock-out block
module ebhco_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst = 1, sel = 0, off_n = 1, emu = 1, dis = 0, a18 = 1, sin = 1;
    logic want = 0, busy = 0, req_n, cb, sel_r, sel_o, sel_oe, rel, ack_n, ack_oe, co, co_oe, p;
    logic en;
    int miscompares = 0, tests_run = 0, n, e;
    ebhco_partner i_bm (.want(want), .busy(busy), .hold_req_n(req_n), .bus_cycle_busy(cb));
    ebhco_top #(.CLK_DIV(2)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .ext_interface_select(sel),
        .off_n(off_n), .emulation_pin_1(emu), .hold_req_n(req_n), .bus_cycle_busy(cb),
        .clock_pin_disable(dis), .program_addr_bit18(a18), .subsystem_select_in(sin),
        .subsystem_select_r(sel_r), .subsystem_select_out_r(sel_o), .subsystem_select_oe_r(sel_oe),
        .bus_release_r(rel), .hold_acknowledge_n_r(ack_n), .hold_acknowledge_oe_r(ack_oe),
        .machine_cycle_clock_out_r(co), .machine_cycle_clock_out_oe_r(co_oe), .machine_cycle_en_r(en));
    initial forever #50 mclk = ~mclk;
    task chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t mismatch", $time);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    task test_done;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task t_hold;
        busy = 1;
        want = 1;
        tick(4);
        chk(ack_n, 1'h1);
        busy = 0;
        n = 0;
        while (ack_n !== 1'h0 && n < 8) begin tick(1); n++; end
        chk(ack_n, 1'h0);
        chk(rel, 1'h1);
        want = 0;
        tick(2);
        chk(ack_n, 1'h1);
        chk(rel, 1'h0);
        busy = 1;
        want = 1;
        tick(2);
        want = 0;
        busy = 0;
        tick(2);
        chk(ack_n, 1'h1);
        $display("hold test done");
    endtask : t_hold
    task t_pins;
        off_n = 0;
        sel = 1;
        tick(2);
        chk(ack_oe, 1'h0);
        chk(sel_oe, 1'h0);
        off_n = 1;
        tick(2);
        chk(ack_oe, 1'h1);
        chk(sel_oe, 1'h1);
        chk(sel_o, 1'h1);
        a18 = 0;
        sin = 0;
        tick(1);
        chk(sel_o, 1'h0);
        chk(sel_r, 1'h1);
        sel = 0;
        tick(2);
        chk(sel_oe, 1'h0);
        chk(sel_r, 1'h0);
        $display("pin test done");
    endtask : t_pins
    task t_clk;
        n = 0;
        e = 0;
        repeat (8) begin
            p = co;
            tick(1);
            n += int'(p === 1'h1 && co === 1'h0);
            e += int'(en === 1'h1 && co === 1'h0);
        end
        chk(n == 4, 1'h1);
        chk(e == 4, 1'h1);
        chk(co_oe, 1'h1);
        dis = 1;
        tick(2);
        chk(co_oe, 1'h0);
        dis = 0;
        emu = 0;
        tick(2);
        chk(co_oe, 1'h0);
        $display("clock test done");
    endtask : t_clk
    initial begin
        tick(16);
        sys_rst = 0;
        t_hold;
        t_pins;
        t_clk;
        test_done;
    end
    // watchdog against a hang
    initial begin
        #100000;
        miscompares++;
        test_done;
    end
endmodule : ebhco_top_tb
